// file: hw/pam_top.sv
// Purpose: realtime profiling and exceptional event detection
// Assumes: target pins asynchronous, configuration ports on core_clk_i
// Notes: tick fractions kept in sixteenths since a clock need not span whole ticks
//
// Functional notes
// - per-block execution time counter is forty bits
// - six selectable tick periods, 10 ns default
// - changing tick period wipes all results
// - sixteen-bit pass counter per block
// - clear wipes results, otherwise they accumulate
// - eight blocks only, unassigned tasks unmeasured
// - time or pass overflow raises profile event
// - section timer overflow raises performance event
// - trace storage overfill raises trace event
// - each event selectable for break or trace
// - five word-granular access attributes
// - disabled-except-OS flags non-OS accesses
// - all words read-write after power-up
// - sixteen protection areas, more is error
// - ROM writes and unused-area accesses flagged
// - stack pointer outside stack area flagged
// - read of never-written monitored word flagged
// - write into another task's stack flagged
// - task switch raises dispatch event
// - results within two ticks plus 100ns
`timescale 1ns/1ps
`include "pam_defs.svh"
module pam_top import pam_pkg::*; #(
	parameter int NBLK = `PAM_NBLK,
	parameter int AW = `PAM_ADDR_W,
	parameter int TIDW = `PAM_TID_W,
	parameter int PERF_W = `PAM_PERF_W,
	parameter int CW = `PAM_CNT_W,
	parameter int TRC_DEPTH = `PAM_TRC_DEPTH
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// target activity pins
	input wire logic tgt_valid_i,
	input wire logic tgt_rd_i,
	input wire logic tgt_wr_i,
	input wire logic tgt_fetch_i,
	input wire logic tgt_os_i,
	input wire logic [AW-1:0] tgt_addr_i,
	input wire logic [AW-1:0] tgt_sp_i,
	input wire logic [TIDW-1:0] tgt_task_i,
	input wire logic tgt_task_sw_i,
	input wire logic tgt_perf_run_i,
	input wire logic tgt_trc_store_i,
	// profile configuration
	input wire logic clr_i,
	input wire logic [2:0] tb_sel_i,
	input wire logic task_mode_i,
	input wire logic [NBLK-1:0] blk_en_i,
	input wire logic [NBLK-1:0][AW-1:0] blk_lo_i,
	input wire logic [NBLK-1:0][AW-1:0] blk_hi_i,
	input wire logic [NBLK-1:0][TIDW-1:0] blk_task_i,
	input wire logic [NBLK-1:0][AW-1:0] tstk_lo_i,
	input wire logic [NBLK-1:0][AW-1:0] tstk_hi_i,
	input wire logic [$clog2(NBLK)-1:0] rd_blk_i,
	// protection and event configuration
	input wire logic attr_we_i,
	input wire logic [AW-1:0] attr_addr_i,
	input wire logic [`PAM_ATTR_W-1:0] attr_i,
	input wire logic area_add_i,
	input wire logic area_clr_i,
	input wire logic [AW-1:0] stk_lo_i,
	input wire logic [AW-1:0] stk_hi_i,
	input wire logic trc_clr_i,
	input wire logic [`PAM_NEV-1:0] brk_sel_i,
	input wire logic [`PAM_NEV-1:0] trc_sel_i,
	// results and events
	output logic [`PAM_TIME_W-1:0] rd_time_o,
	output logic [`PAM_CNT_W-1:0] rd_cnt_o,
	output logic [NBLK-1:0] rtp_ovf_o,
	output logic perf_ovf_o,
	output logic area_err_o,
	output logic attr_busy_o,
	output logic [`PAM_NEV-1:0] evt_o,
	output logic brk_o,
	output logic trcpt_o
);
	localparam int TW = `PAM_TIME_W;
	localparam int TRW = `PAM_TRC_W;

	// sixteenths of a tick that elapse in one clock
	function automatic logic [7:0] tb_step(input logic [2:0] sel);
		case (sel)
			PAM_TB_20NS: tb_step = 8'((`PAM_CLK_NS * `PAM_FRAC) / `PAM_TB1_NS);
			PAM_TB_40NS: tb_step = 8'((`PAM_CLK_NS * `PAM_FRAC) / `PAM_TB2_NS);
			PAM_TB_80NS: tb_step = 8'((`PAM_CLK_NS * `PAM_FRAC) / `PAM_TB3_NS);
			PAM_TB_160NS: tb_step = 8'((`PAM_CLK_NS * `PAM_FRAC) / `PAM_TB4_NS);
			PAM_TB_1600NS: tb_step = 8'((`PAM_CLK_NS * `PAM_FRAC) / `PAM_TB5_NS);
			default: tb_step = 8'((`PAM_CLK_NS * `PAM_FRAC) / `PAM_TB0_NS);
		endcase
	endfunction : tb_step

	function automatic logic in_rng(input logic [AW-1:0] a, input logic [AW-1:0] lo, input logic [AW-1:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction : in_rng

	// two-stage synchronisers for target pins
	logic [7:0] ctl_s1, ctl_s2;
	logic [AW-1:0] addr_s1, addr_s2, sp_s1, sp_s2;
	logic [TIDW-1:0] tid_s1, tid_s2;
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			ctl_s1 <= '0;
			ctl_s2 <= '0;
		end else begin
			ctl_s1 <= {tgt_valid_i, tgt_rd_i, tgt_wr_i, tgt_fetch_i, tgt_os_i, tgt_task_sw_i, tgt_perf_run_i,
				tgt_trc_store_i};
			ctl_s2 <= ctl_s1;
		end
		addr_s1 <= tgt_addr_i;
		addr_s2 <= addr_s1;
		sp_s1 <= tgt_sp_i;
		sp_s2 <= sp_s1;
		tid_s1 <= tgt_task_i;
		tid_s2 <= tid_s1;
	end
	logic acc_v, acc_rd, acc_wr, acc_fe, acc_os, task_sw, perf_run, trc_store;
	assign {acc_v, acc_rd, acc_wr, acc_fe, acc_os, task_sw, perf_run, trc_store} = ctl_s2;

	// attribute memory
	pam_mem_if #(.AW(AW), .ATW(`PAM_ATTR_W)) mif ();
	assign mif.cfg_we = attr_we_i;
	assign mif.cfg_addr = attr_addr_i;
	assign mif.cfg_attr = attr_i;
	assign mif.tgt_addr = addr_s2;
	assign mif.tgt_we = acc_v && acc_wr;
	pam_attr_mem #(.AW(AW), .ATW(`PAM_ATTR_W)) u_mem (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.mif(mif)
	);

	// profiling state
	logic [2:0] tb_q, tb_d;
	logic mode_q, mode_d;
	logic [3:0] res_q, res_d;
	logic [NBLK-1:0] act_q, act_d, ovf_q, ovf_d;
	logic [TW-1:0] time_q [NBLK];
	logic [TW-1:0] time_d [NBLK];
	logic [CW-1:0] cnt_q [NBLK];
	logic [CW-1:0] cnt_d [NBLK];
	logic [PERF_W-1:0] perf_q, perf_d;
	logic perf_ovf_q, perf_ovf_d;
	logic [TRW-1:0] trc_q, trc_d;
	logic wipe;
	logic [3:0] ticks;
	logic [8:0] frac_sum;
	logic [TW:0] tsum;
	logic [PERF_W:0] psum;
	logic rtp_ev;

	always_comb begin
		wipe = clr_i || (tb_sel_i != tb_q) || (task_mode_i != mode_q);
		tb_d = tb_sel_i;
		mode_d = task_mode_i;
		frac_sum = {1'b0, res_q} + {1'b0, tb_step(tb_q)};
		ticks = frac_sum[7:4];
		res_d = wipe ? 4'h0 : frac_sum[3:0];
		rtp_ev = 1'b0;
		for (int i = 0; i < NBLK; i++) begin
			// task mode: only the eight assigned ids are measured
			if (task_mode_i) begin
				act_d[i] = blk_en_i[i] && (tid_s2 == blk_task_i[i]);
			end else if (acc_v && acc_fe) begin
				act_d[i] = blk_en_i[i] && in_rng(addr_s2, blk_lo_i[i], blk_hi_i[i]);
			end else begin
				act_d[i] = act_q[i];
			end
			tsum = {1'b0, time_q[i]} + (act_q[i] ? (TW+1)'(ticks) : '0);
			time_d[i] = tsum[TW-1:0];
			cnt_d[i] = cnt_q[i];
			ovf_d[i] = ovf_q[i] | tsum[TW];
			if (act_d[i] && !act_q[i]) begin
				cnt_d[i] = cnt_q[i] + CW'(1);
				ovf_d[i] = ovf_d[i] | (&cnt_q[i]);
			end
			rtp_ev = rtp_ev | (ovf_d[i] & ~ovf_q[i]);
			if (wipe) begin
				time_d[i] = '0;
				cnt_d[i] = '0;
				ovf_d[i] = ovf_d[i] & ~ovf_q[i]; // new overflow outlives the wipe
			end
		end
		psum = {1'b0, perf_q} + (perf_run ? (PERF_W+1)'(ticks) : '0);
		perf_d = psum[PERF_W-1:0];
		perf_ovf_d = (wipe ? 1'b0 : perf_ovf_q) | psum[PERF_W];
		trc_d = trc_q;
		if (trc_store && (trc_q != TRW'(TRC_DEPTH))) begin
			trc_d = trc_q + TRW'(1);
		end
		if (trc_clr_i) begin
			trc_d = '0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			tb_q <= PAM_TB_10NS;
			mode_q <= 1'b0;
			res_q <= '0;
			act_q <= '0;
			ovf_q <= '0;
			perf_q <= '0;
			perf_ovf_q <= 1'b0;
			trc_q <= '0;
			for (int i = 0; i < NBLK; i++) begin
				time_q[i] <= '0;
				cnt_q[i] <= '0;
			end
		end else begin
			tb_q <= tb_d;
			mode_q <= mode_d;
			res_q <= res_d;
			act_q <= act_d;
			ovf_q <= ovf_d;
			perf_q <= perf_d;
			perf_ovf_q <= perf_ovf_d;
			trc_q <= trc_d;
			time_q <= time_d;
			cnt_q <= cnt_d;
		end
	end

	// exception detection, access checks aligned with memory read data
	logic v_q, rd_q, wr_q, fe_q, os_q, mem_ok;
	logic [AW-1:0] wa_q;
	logic [`PAM_NEV-1:0] ev_d, ev_q;
	logic [`PAM_AREA_CNT_W-1:0] area_q, area_d;
	logic area_err_q, area_err_d, brk_q, brk_d, trp_q, trp_d, tstk_hit;
	logic [`PAM_TIME_W-1:0] rd_time_q;
	logic [`PAM_CNT_W-1:0] rd_cnt_q;
	pam_attr_t kind;

	always_comb begin
		kind = pam_attr_t'(mif.rd_attr[2:0]);
		mem_ok = v_q && !mif.busy;
		ev_d = '0;
		case (kind)
			PAM_RO: ev_d[`PAM_EV_ACC] = mem_ok && wr_q;
			PAM_WO: ev_d[`PAM_EV_ACC] = mem_ok && (rd_q || fe_q);
			PAM_DIS: ev_d[`PAM_EV_ACC] = mem_ok && (rd_q || wr_q || fe_q);
			PAM_DIS_OS: ev_d[`PAM_EV_ACC] = mem_ok && (rd_q || wr_q || fe_q) && !os_q;
			default: ev_d[`PAM_EV_ACC] = 1'b0;
		endcase
		ev_d[`PAM_EV_UNINIT] = mem_ok && rd_q && mif.rd_attr[`PAM_ATTR_MON_BIT] && !mif.rd_init;
		ev_d[`PAM_EV_STACK] = !in_rng(sp_s2, stk_lo_i, stk_hi_i);
		ev_d[`PAM_EV_PERF] = perf_ovf_d && !perf_ovf_q;
		ev_d[`PAM_EV_RTP] = rtp_ev;
		ev_d[`PAM_EV_TRACE] = trc_store && (trc_q == TRW'(TRC_DEPTH)) && !trc_clr_i;
		tstk_hit = 1'b0;
		for (int j = 0; j < NBLK; j++) begin
			tstk_hit = tstk_hit | (blk_en_i[j] && (blk_task_i[j] != tid_s2) && in_rng(addr_s2, tstk_lo_i[j],
				tstk_hi_i[j]));
		end
		ev_d[`PAM_EV_TSTACK] = acc_v && acc_wr && tstk_hit;
		ev_d[`PAM_EV_DISPATCH] = task_sw;
		brk_d = |(ev_d & brk_sel_i);
		trp_d = |(ev_d & trc_sel_i);
		area_d = area_q;
		if (area_add_i && (area_q != `PAM_AREA_CNT_W'(`PAM_NAREA))) begin
			area_d = area_q + `PAM_AREA_CNT_W'(1);
		end
		if (area_clr_i) begin
			area_d = '0;
		end
		area_err_d = (area_clr_i ? 1'b0 : area_err_q) | (area_add_i && (area_q == `PAM_AREA_CNT_W'(`PAM_NAREA)));
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			v_q <= 1'b0;
			ev_q <= '0;
			brk_q <= 1'b0;
			trp_q <= 1'b0;
			area_q <= '0;
			area_err_q <= 1'b0;
			rd_time_q <= '0;
			rd_cnt_q <= '0;
		end else begin
			v_q <= acc_v;
			ev_q <= ev_d;
			brk_q <= brk_d;
			trp_q <= trp_d;
			area_q <= area_d;
			area_err_q <= area_err_d;
			rd_time_q <= time_q[rd_blk_i];
			rd_cnt_q <= `PAM_CNT_W'(cnt_q[rd_blk_i]);
		end
		{rd_q, wr_q, fe_q, os_q} <= {acc_rd, acc_wr, acc_fe, acc_os};
		wa_q <= addr_s2;
	end

	assign rd_time_o = rd_time_q;
	assign rd_cnt_o = rd_cnt_q;
	assign rtp_ovf_o = ovf_q;
	assign perf_ovf_o = perf_ovf_q;
	assign area_err_o = area_err_q;
	assign attr_busy_o = mif.busy;
	assign evt_o = ev_q;
	assign brk_o = brk_q;
	assign trcpt_o = trp_q;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	property p_tick10;
		(tb_q == PAM_TB_10NS) && !wipe && act_q[0] && !time_q[0][TW-1] |=> time_q[0] == $past(time_q[0]) + TW'(10);
	endproperty
	a_tick10: assert property (p_tick10) else $error("10 ns time base did not add ten ticks");
	property p_tb_wipe;
		(tb_sel_i != tb_q) |=> (time_q[0] == '0) && (cnt_q[0] == '0) && (!ovf_q[0] || $past(ovf_d[0] && !ovf_q[0]));
	endproperty
	a_tb_wipe: assert property (p_tb_wipe) else $error("time base change left results");
	property p_clr;
		clr_i |=> (time_q[NBLK-1] == '0) && (cnt_q[NBLK-1] == '0) ##1 (rd_time_o == '0) || (rd_blk_i != $past(rd_blk_i));
	endproperty
	a_clr: assert property (p_clr) else $error("clear left results");
	property p_pass;
		!wipe && act_d[1] && !act_q[1] |=> cnt_q[1] == $past(cnt_q[1]) + CW'(1);
	endproperty
	a_pass: assert property (p_pass) else $error("entry not counted");
	property p_cnt_ovf;
		!wipe && act_d[0] && !act_q[0] && (&cnt_q[0]) |=> ovf_q[0] ##1 evt_o[`PAM_EV_RTP] || ovf_q[0];
	endproperty
	a_cnt_ovf: assert property (p_cnt_ovf) else $error("pass counter overflow missed");
	property p_ovf_hold;
		ovf_q[0] && !wipe |=> ovf_q[0];
	endproperty
	a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag dropped early");
	property p_brk;
		|(ev_d & brk_sel_i) |=> brk_o && (evt_o != '0);
	endproperty
	a_brk: assert property (p_brk) else $error("selected event gave no break");
	property p_os;
		v_q && !mif.busy && (kind == PAM_DIS_OS) && wr_q && !os_q |=> evt_o[`PAM_EV_ACC];
	endproperty
	a_os: assert property (p_os) else $error("non-OS access not flagged");
	property p_area;
		area_add_i && !area_clr_i && (area_q == `PAM_AREA_CNT_W'(`PAM_NAREA)) |=> area_err_o [*2];
	endproperty
	a_area: assert property (p_area) else $error("seventeenth area not refused");
	property p_disp;
		$rose(ctl_s2[2]) |=> evt_o[`PAM_EV_DISPATCH];
	endproperty
	a_disp: assert property (p_disp) else $error("task switch not reported");

endmodule : pam_top

// file: hw/pam_defs.svh
// Purpose: constants of the profile and access monitor
// Assumes: included by bare name from every design file that uses its macros
// Notes: times in ns, fractions of a tick in sixteenths
`ifndef PAM_DEFS_SVH
`define PAM_DEFS_SVH

`define PAM_NBLK 8
`define PAM_TIME_W 40
`define PAM_CNT_W 16
`define PAM_NAREA 16
`define PAM_AREA_CNT_W 5
`define PAM_CLK_NS 100
`define PAM_TB0_NS 10
`define PAM_TB1_NS 20
`define PAM_TB2_NS 40
`define PAM_TB3_NS 80
`define PAM_TB4_NS 160
`define PAM_TB5_NS 1600
`define PAM_FRAC 16
`define PAM_FRAC_BITS 4
`define PAM_ENTRY_ERR_NS 100
`define PAM_TRC_DEPTH 4194304
`define PAM_TRC_W 23
`define PAM_PERF_W 40
`define PAM_ADDR_W 10
`define PAM_TID_W 8
`define PAM_ATTR_W 4
`define PAM_ATTR_MON_BIT 3
`define PAM_NEV 8
`define PAM_EV_ACC 0
`define PAM_EV_UNINIT 1
`define PAM_EV_STACK 2
`define PAM_EV_PERF 3
`define PAM_EV_RTP 4
`define PAM_EV_TRACE 5
`define PAM_EV_TSTACK 6
`define PAM_EV_DISPATCH 7

`endif

// file: hw/pam_pkg.sv
// Purpose: types of the profile and access monitor
// Assumes: nothing
// Notes: attribute codes chosen so that all-zero means read-write
package pam_pkg;

	typedef enum logic [2:0] {
		PAM_RW = 3'h0,
		PAM_RO = 3'h1,
		PAM_WO = 3'h2,
		PAM_DIS = 3'h3,
		PAM_DIS_OS = 3'h4
	} pam_attr_t;

	typedef enum logic [2:0] {
		PAM_TB_10NS = 3'h0,
		PAM_TB_20NS = 3'h1,
		PAM_TB_40NS = 3'h2,
		PAM_TB_80NS = 3'h3,
		PAM_TB_160NS = 3'h4,
		PAM_TB_1600NS = 3'h5
	} pam_tb_t;

	typedef enum logic [1:0] {
		PAM_SWEEP = 2'b01,
		PAM_READY = 2'b10
	} pam_mem_st_t;

endpackage : pam_pkg

// file: hw/pam_mem_if.sv
// Purpose: link between the monitor core and its attribute memory
// Assumes: single clock domain
// Notes: read data arrive one cycle after the address
`timescale 1ns/1ps
interface pam_mem_if #(parameter int AW = 10, parameter int ATW = 4);
	logic cfg_we;
	logic [AW-1:0] cfg_addr;
	logic [ATW-1:0] cfg_attr;
	logic [AW-1:0] tgt_addr;
	logic tgt_we;
	logic [ATW-1:0] rd_attr;
	logic rd_init;
	logic busy;
	modport mem (input cfg_we, cfg_addr, cfg_attr, tgt_addr, tgt_we, output rd_attr, rd_init, busy);
	modport user (output cfg_we, cfg_addr, cfg_attr, tgt_addr, tgt_we, input rd_attr, rd_init, busy);
endinterface : pam_mem_if

// file: hw/pam_attr_mem.sv
// Purpose: per-word access attribute and written-flag memory
// Assumes: host writes ignored while busy
// Notes: after reset every word is swept to read-write and unwritten
`timescale 1ns/1ps
`include "pam_defs.svh"
module pam_attr_mem import pam_pkg::*; #(
	parameter int AW = `PAM_ADDR_W,
	parameter int ATW = `PAM_ATTR_W
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// core side
	pam_mem_if.mem mif
);
	logic [ATW-1:0] attr_mem [2**AW];
	logic init_mem [2**AW];
	pam_mem_st_t st_q, st_d;
	logic [AW-1:0] sweep_q, sweep_d;
	logic [ATW-1:0] rd_attr_q;
	logic rd_init_q;

	always_comb begin
		st_d = st_q;
		sweep_d = sweep_q;
		case (st_q)
			PAM_SWEEP: begin
				sweep_d = sweep_q + AW'(1);
				if (&sweep_q) begin
					st_d = PAM_READY;
				end
			end
			PAM_READY: begin
				st_d = PAM_READY;
			end
			default: begin
				st_d = PAM_SWEEP;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			st_q <= PAM_SWEEP;
			sweep_q <= '0;
		end else begin
			st_q <= st_d;
			sweep_q <= sweep_d;
		end
	end

	// sweep writes read-write into every word
	always_ff @(posedge core_clk_i) begin
		if (st_q != PAM_READY) begin
			attr_mem[sweep_q] <= '0;
			init_mem[sweep_q] <= 1'b0;
		end else begin
			if (mif.cfg_we) begin
				attr_mem[mif.cfg_addr] <= mif.cfg_attr;
			end
			if (mif.tgt_we) begin
				init_mem[mif.tgt_addr] <= 1'b1;
			end
		end
		rd_attr_q <= attr_mem[mif.tgt_addr];
		rd_init_q <= init_mem[mif.tgt_addr];
	end

	assign mif.rd_attr = rd_attr_q;
	assign mif.rd_init = rd_init_q;
	assign mif.busy = st_q[0]; // sweep state bit, straight from the flop

endmodule : pam_attr_mem

// file: dv/pam_tgt_model.sv
// Purpose: target processor activity on the monitor pins
// Assumes: tasks called by the bench just after a rising edge
// Notes: idle address lines show the inverse of the last address
`timescale 1ns/1ps
module pam_tgt_model #(
	parameter int AW = 4,
	parameter int TIDW = 8
) (
	// clock
	input wire logic core_clk_i,
	// bus accesses
	output logic tgt_valid_o,
	output logic tgt_rd_o,
	output logic tgt_wr_o,
	output logic tgt_fetch_o,
	output logic tgt_os_o,
	output logic [AW-1:0] tgt_addr_o,
	// execution state
	output logic [AW-1:0] tgt_sp_o,
	output logic [TIDW-1:0] tgt_task_o,
	output logic tgt_task_sw_o,
	output logic tgt_perf_run_o,
	output logic tgt_trc_store_o
);
	initial begin
		{tgt_valid_o, tgt_rd_o, tgt_wr_o, tgt_fetch_o, tgt_os_o} = 5'h00;
		tgt_addr_o = '0;
		tgt_sp_o = '0;
		tgt_task_o = '0;
		{tgt_task_sw_o, tgt_perf_run_o, tgt_trc_store_o} = 3'h0;
	end

	// one access held for n cycles, then released
	task automatic acc(input logic r, input logic w, input logic f, input logic o, input logic [AW-1:0] a, input int n);
		@(posedge core_clk_i);
		#1;
		{tgt_valid_o, tgt_rd_o, tgt_wr_o, tgt_fetch_o, tgt_os_o} = {1'b1, r, w, f, o};
		tgt_addr_o = a;
		repeat (n) @(posedge core_clk_i);
		#1;
		{tgt_valid_o, tgt_rd_o, tgt_wr_o, tgt_fetch_o, tgt_os_o} = 5'h00;
		tgt_addr_o = ~a;
	endtask : acc

	// state held for n cycles and kept until the next call
	task automatic ctl(input logic [AW-1:0] s, input logic [TIDW-1:0] t, input logic [2:0] m, input int n);
		@(posedge core_clk_i);
		#1;
		tgt_sp_o = s;
		tgt_task_o = t;
		{tgt_task_sw_o, tgt_perf_run_o, tgt_trc_store_o} = m;
		repeat (n - 1) @(posedge core_clk_i);
	endtask : ctl
endmodule : pam_tgt_model

// file: dv/tb_pam_top.sv
// Purpose: self-checking bench of the profile and access monitor
// Assumes: short address, trace and section timer parameters
// Notes: event pulses are counted every cycle and compared per scenario
`timescale 1ns/1ps
module tb_pam_top import pam_pkg::*;;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic clr = 1'b0, tmode = 1'b0, awe = 1'b0, aadd = 1'b0, aclr = 1'b0, tclr = 1'b0;
	logic [2:0] tbs = 3'h0, rdb = 3'h0;
	logic [7:0] ben = 8'h00, bsel, tsel, rovf, evt, tid;
	logic [7:0][3:0] blo = '0, bhi = '0, tlo = '0, thi = '0;
	logic [7:0][7:0] btk = '0;
	logic [3:0] aad = 4'h0, atr = 4'h0, slo = 4'h0, shi = 4'hf, ta, sp;
	logic [39:0] rtime;
	logic [15:0] rcnt;
	logic povf, aerr, busy, brk, tp, v, rd, wr, fe, os, sw, run, st;
	int error_cnt = 0, checked = 0, bm = 0, tm = 0, seed = 32'h5441_9169;
	int ev_n[8];

	pam_top #(.AW(4), .PERF_W(8), .CW(4), .TRC_DEPTH(8)) u_dut (
		.core_clk_i(clk), .rst_i(rst), .tgt_valid_i(v), .tgt_rd_i(rd), .tgt_wr_i(wr), .tgt_fetch_i(fe),
		.tgt_os_i(os), .tgt_addr_i(ta), .tgt_sp_i(sp), .tgt_task_i(tid), .tgt_task_sw_i(sw),
		.tgt_perf_run_i(run), .tgt_trc_store_i(st), .clr_i(clr), .tb_sel_i(tbs), .task_mode_i(tmode),
		.blk_en_i(ben), .blk_lo_i(blo), .blk_hi_i(bhi), .blk_task_i(btk), .tstk_lo_i(tlo), .tstk_hi_i(thi),
		.rd_blk_i(rdb), .attr_we_i(awe), .attr_addr_i(aad), .attr_i(atr), .area_add_i(aadd),
		.area_clr_i(aclr), .stk_lo_i(slo), .stk_hi_i(shi), .trc_clr_i(tclr), .brk_sel_i(bsel),
		.trc_sel_i(tsel), .rd_time_o(rtime), .rd_cnt_o(rcnt), .rtp_ovf_o(rovf), .perf_ovf_o(povf),
		.area_err_o(aerr), .attr_busy_o(busy), .evt_o(evt), .brk_o(brk), .trcpt_o(tp)
	);

	pam_tgt_model #(.AW(4), .TIDW(8)) u_tgt (
		.core_clk_i(clk), .tgt_valid_o(v), .tgt_rd_o(rd), .tgt_wr_o(wr), .tgt_fetch_o(fe), .tgt_os_o(os),
		.tgt_addr_o(ta), .tgt_sp_o(sp), .tgt_task_o(tid), .tgt_task_sw_o(sw), .tgt_perf_run_o(run),
		.tgt_trc_store_o(st)
	);

	initial begin
		forever #50 clk = ~clk;
	end

	always @(posedge clk) begin
		if (!rst) begin
			foreach (ev_n[b]) ev_n[b] <= ev_n[b] + int'(evt[b]);
			if (brk !== |(evt & bsel)) bm <= bm + 1;
			if (tp !== |(evt & tsel)) tm <= tm + 1;
		end
	end

	function automatic logic viol(input int at, input int op, input logic o);
		case (at)
			1: return op == 1;
			2: return op != 1;
			3: return 1'b1;
			4: return !o;
			default: return 1'b0;
		endcase
	endfunction : viol

	function automatic int tbns(input int k);
		case (k)
			0: return 10;
			1: return 20;
			2: return 40;
			3: return 80;
			4: return 160;
			default: return 1600;
		endcase
	endfunction : tbns

	task automatic test_done();
		$display("checked=%0d error_cnt=%0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : test_done

	task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s exp=%0h got=%0h", n, e, g);
		end
	endtask : chk

	// measured time against expected ns, tolerance of three entries plus latency
	task automatic chkr(input string n, input longint e, input logic [39:0] g, input int t);
		longint d;
		longint tol;
		checked++;
		d = longint'(g) * t - e;
		tol = 3 * (2 * t + 100) + 600;
		if (^g === 1'bx || d > tol || d < -tol) begin
			error_cnt++;
			$display("[FAIL] %s exp=%0d got=%0d", n, e, d + e);
		end
	endtask : chkr

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle

	task automatic pulse(ref logic s);
		@(posedge clk);
		#1;
		s = 1'b1;
		@(posedge clk);
		#1;
		s = 1'b0;
	endtask : pulse

	task automatic zero();
		@(posedge clk);
		#1;
		foreach (ev_n[b]) ev_n[b] = 0;
	endtask : zero

	task automatic wattr(input logic [3:0] a, input logic [3:0] d);
		@(posedge clk);
		#1;
		awe = 1'b1;
		aad = a;
		atr = d;
		@(posedge clk);
		#1;
		awe = 1'b0;
	endtask : wattr

	task automatic prof();
		u_tgt.acc(1'b0, 1'b0, 1'b1, 1'b0, 4'h9, 30);
		u_tgt.acc(1'b0, 1'b0, 1'b1, 1'b0, 4'h0, 5);
	endtask : prof

	initial begin
		repeat (30000) @(posedge clk);
		error_cnt++;
		test_done();
	end

	initial begin
		int k, a, o;
		int spv[4] = '{3, 4, 9, 10};
		bsel = $random(seed);
		tsel = $random(seed);
		settle(4);
		rst = 1'b0;
		chk("busy", 1, busy);
		chk("evt", 0, evt);
		for (k = 0; k < 40 && busy !== 1'b0; k++) @(posedge clk);
		settle(1);
		chk("busy", 0, busy);
		wattr(4'h3, 4'h8);
		zero();
		u_tgt.acc(1'b1, 1'b0, 1'b0, 1'b0, 4'h3, 1);
		u_tgt.acc(1'b0, 1'b1, 1'b0, 1'b0, 4'h3, 1);
		u_tgt.acc(1'b1, 1'b0, 1'b0, 1'b0, 4'h3, 1);
		settle(8);
		chk("uninit", 1, ev_n[1]);
		for (k = 0; k < 8; k++) begin
			a = $random(seed);
			u_tgt.acc(k % 3 == 0, k % 3 == 1, k % 3 == 2, a[4], a[3:0], 1);
		end
		settle(8);
		chk("acc_reset", 0, ev_n[0]);
		for (k = 0; k < 30; k++) begin
			a = $random(seed);
			o = $random(seed);
			wattr(a[3:0], 4'(k % 5));
			zero();
			u_tgt.acc(k / 5 % 3 == 0, k / 5 % 3 == 1, k / 5 % 3 == 2, o[0], a[3:0], 1);
			settle(8);
			chk("acc", viol(k % 5, k / 5 % 3, o[0]), ev_n[0]);
		end
		u_tgt.ctl(4'h5, 8'h06, 3'h0, 1);
		slo = 4'h4;
		shi = 4'h9;
		settle(4);
		for (k = 0; k < 4; k++) begin
			zero();
			u_tgt.ctl(4'(spv[k]), 8'h06, 3'h0, 1);
			u_tgt.ctl(4'h5, 8'h06, 3'h0, 1);
			settle(8);
			chk("stack", k == 0 || k == 3, ev_n[2]);
		end
		zero();
		u_tgt.ctl(4'h5, 8'h06, 3'h4, 2);
		u_tgt.ctl(4'h5, 8'h06, 3'h0, 1);
		settle(8);
		chk("dispatch", 2, ev_n[7]);
		pulse(tclr);
		zero();
		u_tgt.ctl(4'h5, 8'h06, 3'h1, 10);
		u_tgt.ctl(4'h5, 8'h06, 3'h0, 1);
		settle(8);
		chk("trace", 2, ev_n[5]);
		zero();
		u_tgt.ctl(4'h5, 8'h06, 3'h2, 300);
		u_tgt.ctl(4'h5, 8'h06, 3'h0, 1);
		settle(8);
		chk("perf_evt", 1, ev_n[3] > 0);
		chk("perf_ovf", 1, povf);
		pulse(clr);
		settle(3);
		chk("perf_ovf", 0, povf);
		ben = 8'h01;
		btk[0] = 8'h05;
		tlo[0] = 4'h2;
		thi[0] = 4'h3;
		for (k = 0; k < 3; k++) begin
			zero();
			u_tgt.ctl(4'h5, (k == 1) ? 8'h05 : 8'h06, 3'h0, 1);
			u_tgt.acc(1'b0, 1'b1, 1'b0, 1'b0, (k == 2) ? 4'h4 : 4'h2, 1);
			settle(8);
			chk("tstack", k == 0, ev_n[6]);
		end
		pulse(aclr);
		repeat (16) pulse(aadd);
		settle(2);
		chk("area_err", 0, aerr);
		pulse(aadd);
		settle(2);
		chk("area_err", 1, aerr);
		pulse(aclr);
		settle(2);
		chk("area_err", 0, aerr);
		blo[0] = 4'h8;
		bhi[0] = 4'hb;
		for (k = 0; k < 6; k++) begin
			tbs = 3'(k);
			settle(3);
			chk("time_wipe", 0, rtime);
			chk("cnt_wipe", 0, rcnt);
			repeat (3) prof();
			settle(6);
			chk("cnt", 3, rcnt);
			chkr("time", 9000, rtime, tbns(k));
		end
		repeat (3) prof();
		settle(6);
		chk("cnt_acc", 6, rcnt);
		pulse(clr);
		settle(3);
		chk("time_clr", 0, rtime);
		chk("cnt_clr", 0, rcnt);
		// sixteen short entries wrap the narrow pass counter
		zero();
		repeat (16) begin
			u_tgt.acc(1'b0, 1'b0, 1'b1, 1'b0, 4'h9, 1);
			u_tgt.acc(1'b0, 1'b0, 1'b1, 1'b0, 4'h0, 1);
		end
		settle(6);
		chk("rtp_ovf", 8'h01, rovf);
		chk("rtp_evt", 1, ev_n[4]);
		chk("cnt_wrap", 0, rcnt);
		pulse(clr);
		settle(3);
		chk("rtp_ovf", 0, rovf);
		// task mode: only the id owning block 0 is measured
		tmode = 1'b1;
		tbs = 3'h0;
		u_tgt.ctl(4'h5, 8'h07, 3'h0, 20);
		settle(1);
		chk("task_free", 0, rcnt);
		u_tgt.ctl(4'h5, 8'h05, 3'h0, 31);
		u_tgt.ctl(4'h5, 8'h07, 3'h0, 4);
		settle(4);
		chk("task_cnt", 1, rcnt);
		chkr("task_time", 3100, rtime, 10);
		chk("brk", 0, bm);
		chk("trcpt", 0, tm);
		test_done();
	end
endmodule : tb_pam_top
